/* File: logic/inco_device.sv */
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
`include "inco_regs.svh"
module inco_device #(
   parameter int W = 16
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   inco_if.dev               link,
   output logic [W-1:0]      out_i_o,
   output logic [W-1:0]      out_q_o,
   output logic              out_valid_o
);

   logic [7:0]          cfg_a;
   logic [7:0]          cfg_b;
   logic [7:0]          cfg_c;
   logic [7:0]          ftw_byte [4];
   logic [7:0]          upd_reg;
   logic [31:0]         ftw_active;
   logic [31:0]         acc;
   logic [2:0]          cnt;
   logic [2:0]          act;
   logic [1:0]          nact;
   logic [1:0]          upto [3];
   logic [2:0]          step [3];
   logic [2:0]          tick;
   logic                in_tick;
   logic                nco_tick;
   logic                pm_ph;
   logic signed [W-1:0] st_i [4];
   logic signed [W-1:0] st_q [4];
   logic signed [W-1:0] sin_in_i [3];
   logic signed [W-1:0] sin_in_q [3];
   logic signed [W-1:0] nco_i;
   logic signed [W-1:0] nco_q;
   logic signed [15:0]  car_c;
   logic signed [15:0]  car_s;
   logic signed [W+16:0] mix_i;
   logic signed [W+16:0] mix_q;

   function automatic logic [2:0] lowmask(input logic [1:0] n);
      case (n)
         2'h0:    lowmask = 3'h0;
         2'h1:    lowmask = 3'h1;
         2'h2:    lowmask = 3'h3;
         default: lowmask = 3'h7;
      endcase
   endfunction : lowmask

   // rotation by p eighths of a turn, the coarse mixing of one stage sample
   function automatic logic [2*W-1:0] rot8(input logic signed [W-1:0] a, input logic signed [W-1:0] b,
                                          input logic [2:0] p);
      logic signed [W:0]    sp;
      logic signed [W:0]    sm;
      logic signed [W+17:0] rp;
      logic signed [W+17:0] rm;
      logic signed [W-1:0]  hp;
      logic signed [W-1:0]  hm;
      sp = a + b;
      sm = a - b;
      rp = sp * `INCO_ROT_R;
      rm = sm * `INCO_ROT_R;
      hp = rp[W+14:15];
      hm = rm[W+14:15];
      case (p)
         3'h0:    rot8 = {a, b};
         3'h1:    rot8 = {hm, hp};
         3'h2:    rot8 = {-b, a};
         3'h3:    rot8 = {-hp, hm};
         3'h4:    rot8 = {-a, -b};
         3'h5:    rot8 = {-hm, -hp};
         3'h6:    rot8 = {b, -a};
         default: rot8 = {hp, -hm};
      endcase
   endfunction : rot8

   // first quarter of a 64-point sine, Q15
   function automatic logic signed [15:0] qsin(input logic [4:0] k);
      case (k)
         5'h00:   qsin = 16'h0000;
         5'h01:   qsin = 16'h0C8C;
         5'h02:   qsin = 16'h18F9;
         5'h03:   qsin = 16'h2528;
         5'h04:   qsin = 16'h30FB;
         5'h05:   qsin = 16'h3C56;
         5'h06:   qsin = 16'h471C;
         5'h07:   qsin = 16'h5133;
         5'h08:   qsin = 16'h5A82;
         5'h09:   qsin = 16'h62F1;
         5'h0A:   qsin = 16'h6A6D;
         5'h0B:   qsin = 16'h70E2;
         5'h0C:   qsin = 16'h7641;
         5'h0D:   qsin = 16'h7A7C;
         5'h0E:   qsin = 16'h7D89;
         5'h0F:   qsin = 16'h7F61;
         default: qsin = 16'h7FFF;
      endcase
   endfunction : qsin

   function automatic logic signed [15:0] sin6(input logic [5:0] p);
      logic signed [15:0] mag;
      mag  = p[4] ? qsin(5'h10 - {1'b0, p[3:0]}) : qsin({1'b0, p[3:0]});
      sin6 = p[5] ? -mag : mag;
   endfunction : sin6

   // register writes; mode registers steer the datapath on the next clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cfg_a   <= `INCO_CFG_A_RST;
         cfg_b   <= `INCO_CFG_RST;
         cfg_c   <= `INCO_CFG_RST;
         upd_reg <= `INCO_CFG_RST;
         for (int n = 0; n < 4; n++) begin
            ftw_byte[n] <= `INCO_CFG_RST;
         end
      end else if (ce_i && link.reg_wr) begin
         case (link.reg_addr)
            `INCO_CFG_A:   cfg_a <= link.reg_wdata;
            `INCO_CFG_B:   cfg_b <= link.reg_wdata;
            `INCO_CFG_C:   cfg_c <= link.reg_wdata;
            `INCO_FTW0:    ftw_byte[0] <= link.reg_wdata;
            `INCO_FTW1:    ftw_byte[1] <= link.reg_wdata;
            `INCO_FTW2:    ftw_byte[2] <= link.reg_wdata;
            `INCO_FTW3:    ftw_byte[3] <= link.reg_wdata;
            `INCO_FTW_UPD: upd_reg <= link.reg_wdata;
            default:       ;
         endcase
      end
   end

   // staged bytes reach the oscillator only on a written 0 to 1 of bit 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ftw_active <= `INCO_FTW_RST;
      end else if (ce_i && link.reg_wr && link.reg_addr == `INCO_FTW_UPD &&
                   link.reg_wdata[0] && !upd_reg[0]) begin
         ftw_active <= {ftw_byte[3], ftw_byte[2], ftw_byte[1], ftw_byte[0]};
      end
   end

   // read-back; unmapped offsets read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         link.reg_rdata  <= 8'h00;
         link.reg_rvalid <= 1'b0;
      end else if (ce_i) begin
         link.reg_rvalid <= link.reg_rd;
         if (link.reg_rd) begin
            case (link.reg_addr)
               `INCO_CFG_A:   link.reg_rdata <= cfg_a;
               `INCO_CFG_B:   link.reg_rdata <= cfg_b;
               `INCO_CFG_C:   link.reg_rdata <= cfg_c;
               `INCO_FTW0:    link.reg_rdata <= ftw_byte[0];
               `INCO_FTW1:    link.reg_rdata <= ftw_byte[1];
               `INCO_FTW2:    link.reg_rdata <= ftw_byte[2];
               `INCO_FTW3:    link.reg_rdata <= ftw_byte[3];
               `INCO_FTW_UPD: link.reg_rdata <= upd_reg;
               default:       link.reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // rate plan: each active stage doubles the rate, output runs at clk
   assign act[0]  = ~cfg_a[`INCO_A_HB1_BYP];
   assign act[1]  = ~cfg_a[`INCO_A_HB2_BYP];
   assign act[2]  = ~cfg_a[`INCO_A_HB3_BYP];
   assign upto[0] = {1'b0, act[0]};
   assign upto[1] = upto[0] + {1'b0, act[1]};
   assign upto[2] = upto[1] + {1'b0, act[2]};
   assign nact    = upto[2];
   assign in_tick = (cnt & lowmask(nact)) == 3'h0;
   assign link.smp_ready = ce_i & in_tick;

   // stage steps in eighths of a turn per output sample
   assign step[0] = {cfg_a[`INCO_A_HB1_MSB:`INCO_A_HB1_LSB], 1'b0};
   assign step[1] = cfg_b[2:0];
   assign step[2] = cfg_c[2:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 3'h0;
      end else if (ce_i) begin
         cnt <= cnt + 3'h1;
      end
   end

   // input capture with optional half-rate premodulation; a missing sample enters as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_i[0] <= '0;
         st_q[0] <= '0;
         pm_ph   <= 1'b0;
      end else if (ce_i && in_tick) begin
         pm_ph <= cfg_a[`INCO_A_PREMOD] ? ~pm_ph : 1'b0;
         if (!link.smp_valid) begin
            st_i[0] <= '0;
            st_q[0] <= '0;
         end else if (pm_ph) begin
            st_i[0] <= -link.smp_i;
            st_q[0] <= -link.smp_q;
         end else begin
            st_i[0] <= link.smp_i;
            st_q[0] <= link.smp_q;
         end
      end
   end

   assign sin_in_i[0] = st_i[0];
   assign sin_in_q[0] = st_q[0];
   assign sin_in_i[1] = nco_i;
   assign sin_in_q[1] = nco_q;
   assign sin_in_i[2] = st_i[2];
   assign sin_in_q[2] = st_q[2];

   // sample-and-hold interpolation: the half-band coefficients live outside this block,
   // so images are not suppressed here; only rate and coarse shift are exact
   for (genvar k = 0; k < 3; k++) begin : g_stage
      logic [2:0] ph;
      assign tick[k] = (cnt & lowmask(nact - upto[k])) == 3'h0;
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            ph        <= 3'h0;
            st_i[k+1] <= '0;
            st_q[k+1] <= '0;
         end else if (ce_i) begin
            if (!act[k]) begin
               ph        <= 3'h0;
               st_i[k+1] <= sin_in_i[k];
               st_q[k+1] <= sin_in_q[k];
            end else if (tick[k]) begin
               ph <= ph + step[k];
               {st_i[k+1], st_q[k+1]} <= rot8(sin_in_i[k], sin_in_q[k], ph);
            end
         end
      end
   end

   // oscillator sits after the first stage, so its rate follows that stage
   assign nco_tick = act[0] ? tick[0] : in_tick;
   assign car_c    = sin6(acc[31:26] + 6'h10);
   assign car_s    = sin6(acc[31:26]);
   assign mix_i    = st_i[1] * car_c - st_q[1] * car_s;
   assign mix_q    = st_i[1] * car_s + st_q[1] * car_c;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc   <= 32'h00000000;
         nco_i <= '0;
         nco_q <= '0;
      end else if (ce_i && nco_tick) begin
         if (cfg_a[`INCO_A_NCO_EN]) begin
            acc   <= acc + ftw_active;
            nco_i <= mix_i[W+14:15];
            nco_q <= mix_q[W+14:15];
         end else begin
            acc   <= 32'h00000000;
            nco_i <= st_i[1];
            nco_q <= st_q[1];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_i_o     <= '0;
         out_q_o     <= '0;
         out_valid_o <= 1'b0;
      end else if (ce_i) begin
         out_i_o     <= st_i[3];
         out_q_o     <= st_q[3];
         out_valid_o <= 1'b1;
      end
   end

endmodule : inco_device

/* File: logic/inco_regs.svh */
`ifndef INCO_REGS_SVH
`define INCO_REGS_SVH

// device register offsets on the byte-wide control port
`define INCO_CFG_A        8'h1C
`define INCO_CFG_B        8'h1D
`define INCO_CFG_C        8'h1E
`define INCO_FTW0         8'h30
`define INCO_FTW1         8'h31
`define INCO_FTW2         8'h32
`define INCO_FTW3         8'h33
`define INCO_FTW_UPD      8'h36

// fields of cfg_a
`define INCO_A_HB1_LSB    0
`define INCO_A_HB1_MSB    1
`define INCO_A_PREMOD     2
`define INCO_A_NCO_EN     3
`define INCO_A_HB1_BYP    4
`define INCO_A_HB2_BYP    5
`define INCO_A_HB3_BYP    6

// reset values: every stage bypassed, oscillator off
`define INCO_CFG_A_RST    8'h70
`define INCO_CFG_RST      8'h00
`define INCO_FTW_RST      32'h00000000

// sqrt(2)/2 in Q15
`define INCO_ROT_R        17'sh05A82

// host wishbone offsets (byte addresses)
`define INCO_WB_CMD       8'h00
`define INCO_WB_STATUS    8'h04
`define INCO_WB_SAMPLE    8'h08
`define INCO_WB_TUNE      8'h0C
`define INCO_WB_MODE      8'h10

// host command / mode fields
`define INCO_CMD_RD       16
`define INCO_ST_BUSY      0
`define INCO_ST_PEND      1
`define INCO_TUNE_OPS     3'h6
`define INCO_MODE_OPS     3'h3

`endif

/* File: logic/inco_pkg.sv */
package inco_pkg;

   typedef enum logic [1:0] {
      INCO_IDLE   = 2'b00,
      INCO_RUN    = 2'b01,
      INCO_RDREQ  = 2'b10,
      INCO_RDWAIT = 2'b11
   } inco_seq_t;

   typedef enum logic [1:0] {
      INCO_X1 = 2'b00,
      INCO_X2 = 2'b01,
      INCO_X4 = 2'b10,
      INCO_X8 = 2'b11
   } inco_factor_t;

   typedef logic [15:0] inco_op_t;

endpackage : inco_pkg

/* File: logic/inco_if.sv */
`timescale 1ns/1ps
interface inco_if #(parameter int W = 16);
   logic         reg_wr;
   logic         reg_rd;
   logic [7:0]   reg_addr;
   logic [7:0]   reg_wdata;
   logic [7:0]   reg_rdata;
   logic         reg_rvalid;
   logic         smp_valid;
   logic         smp_ready;
   logic [W-1:0] smp_i;
   logic [W-1:0] smp_q;

   modport dev (
      input  reg_wr, reg_rd, reg_addr, reg_wdata, smp_valid, smp_i, smp_q,
      output reg_rdata, reg_rvalid, smp_ready
   );

   modport host (
      output reg_wr, reg_rd, reg_addr, reg_wdata, smp_valid, smp_i, smp_q,
      input  reg_rdata, reg_rvalid, smp_ready
   );
endinterface : inco_if

/* File: logic/inco_host.sv */
`timescale 1ns/1ps
`include "inco_regs.svh"
module inco_host #(
   parameter int W = 16
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   inco_if.host             link
);

   inco_pkg::inco_seq_t     state;
   inco_pkg::inco_op_t      ops [6];
   inco_pkg::inco_factor_t  fac;
   logic [2:0]              n_ops;
   logic [2:0]              idx;
   logic [7:0]              rd_addr;
   logic [7:0]              rd_byte;
   logic                    pend;
   logic                    req;
   logic                    idle;
   logic                    take;
   logic [7:0]              mode_a;
   logic [2:0]              m2;
   logic [2:0]              m3;

   assign req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
   assign idle = state == inco_pkg::INCO_IDLE;
   assign fac  = inco_pkg::inco_factor_t'(wb_dat_i[11:10]);
   assign m2   = wb_dat_i[6:4];
   assign m3   = wb_dat_i[9:7];

   // job registers wait while the sequencer is busy; a full sample slot stalls too
   always_comb begin
      take = req;
      if (wb_we_i) begin
         case (wb_adr_i)
            `INCO_WB_CMD, `INCO_WB_TUNE, `INCO_WB_MODE: take = req & idle;
            `INCO_WB_SAMPLE:                            take = req & ~pend;
            default:                                    take = req;
         endcase
      end
   end

   // stage bypasses follow the factor; low-power 4x uses stages two and three
   always_comb begin
      mode_a = {1'b0, 3'b000, wb_dat_i[3:0]};
      case (fac)
         inco_pkg::INCO_X8: mode_a[6:4] = 3'b000;
         inco_pkg::INCO_X4: mode_a[6:4] = wb_dat_i[12] ? 3'b001 : 3'b100;
         inco_pkg::INCO_X2: mode_a[6:4] = 3'b110;
         default:           mode_a[6:4] = 3'b111;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else if (ce_i) begin
         wb_ack_o <= take;
         if (take && !wb_we_i) begin
            wb_dat_o <= (wb_adr_i == `INCO_WB_STATUS) ?
                        {16'h0000, rd_byte, 6'h00, pend, ~idle} : 32'h00000000;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend        <= 1'b0;
         link.smp_i  <= '0;
         link.smp_q  <= '0;
      end else if (ce_i) begin
         if (take && wb_we_i && wb_adr_i == `INCO_WB_SAMPLE) begin
            pend       <= 1'b1;
            link.smp_i <= wb_dat_i[W-1:0];
            link.smp_q <= wb_dat_i[16+W-1:16];
         end else if (link.smp_ready) begin
            pend <= 1'b0;
         end
      end
   end
   assign link.smp_valid = pend;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= inco_pkg::INCO_IDLE;
         n_ops   <= 3'h0;
         idx     <= 3'h0;
         rd_addr <= 8'h00;
         rd_byte <= 8'h00;
         for (int n = 0; n < 6; n++) begin
            ops[n] <= 16'h0000;
         end
      end else if (ce_i) begin
         case (state)
            inco_pkg::INCO_IDLE: begin
               idx <= 3'h0;
               if (take && wb_we_i) begin
                  case (wb_adr_i)
                     `INCO_WB_CMD: begin
                        if (wb_dat_i[`INCO_CMD_RD]) begin
                           rd_addr <= wb_dat_i[15:8];
                           state   <= inco_pkg::INCO_RDREQ;
                        end else begin
                           ops[0] <= wb_dat_i[15:0];
                           n_ops  <= 3'h1;
                           state  <= inco_pkg::INCO_RUN;
                        end
                     end
                     `INCO_WB_TUNE: begin
                        ops[0] <= {`INCO_FTW0, wb_dat_i[7:0]};
                        ops[1] <= {`INCO_FTW1, wb_dat_i[15:8]};
                        ops[2] <= {`INCO_FTW2, wb_dat_i[23:16]};
                        ops[3] <= {`INCO_FTW3, wb_dat_i[31:24]};
                        ops[4] <= {`INCO_FTW_UPD, 8'h00};
                        ops[5] <= {`INCO_FTW_UPD, 8'h01};
                        n_ops  <= `INCO_TUNE_OPS;
                        state  <= inco_pkg::INCO_RUN;
                     end
                     `INCO_WB_MODE: begin
                        ops[0] <= {`INCO_CFG_A, mode_a};
                        ops[1] <= {`INCO_CFG_B, 2'b00, m2, m2};
                        ops[2] <= {`INCO_CFG_C, 2'b00, m3, m3};
                        n_ops  <= `INCO_MODE_OPS;
                        state  <= inco_pkg::INCO_RUN;
                     end
                     default: ;
                  endcase
               end
            end
            inco_pkg::INCO_RUN: begin
               idx <= idx + 3'h1;
               if (idx + 3'h1 == n_ops) begin
                  state <= inco_pkg::INCO_IDLE;
               end
            end
            inco_pkg::INCO_RDREQ: state <= inco_pkg::INCO_RDWAIT;
            inco_pkg::INCO_RDWAIT: begin
               if (link.reg_rvalid) begin
                  rd_byte <= link.reg_rdata;
                  state   <= inco_pkg::INCO_IDLE;
               end
            end
            default: state <= inco_pkg::INCO_IDLE;
         endcase
      end
   end

   // jobs go out in the order software writes them; each runs to the end first
   assign link.reg_wr    = ce_i & (state == inco_pkg::INCO_RUN);
   assign link.reg_rd    = ce_i & (state == inco_pkg::INCO_RDREQ);
   assign link.reg_addr  = (state == inco_pkg::INCO_RUN) ? ops[idx][15:8] : rd_addr;
   assign link.reg_wdata = ops[idx][7:0];

endmodule : inco_host

/* File: tb/inco_sva.sv */
`timescale 1ns/1ps
module inco_sva #(parameter int W = 16) (
   input wire logic         clk_i,
   input wire logic         rst_i,
   input wire logic         ce_i,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [7:0]   reg_addr,
   input wire logic [7:0]   reg_wdata,
   input wire logic [7:0]   reg_rdata,
   input wire logic         reg_rvalid,
   input wire logic         smp_valid,
   input wire logic         smp_ready,
   input wire logic [W-1:0] smp_i,
   input wire logic [W-1:0] smp_q
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // trigger goes 0 then 1 so the stored bit always sees a rise
   sequence s_word_tail;
      reg_wr && reg_addr == 8'h31 ##1 reg_wr && reg_addr == 8'h32 ##1 reg_wr && reg_addr == 8'h33
      ##1 reg_wr && reg_addr == 8'h36 && !reg_wdata[0] ##1 reg_wr && reg_addr == 8'h36 && reg_wdata[0];
   endsequence
   sequence s_mode_tail;
      reg_wr && reg_addr == 8'h1D ##1 reg_wr && reg_addr == 8'h1E;
   endsequence
   a_word_order: assert property (reg_wr && reg_addr == 8'h30 |=> s_word_tail)
      else $error("tuning word bytes out of order");
   a_mode_order: assert property (reg_wr && reg_addr == 8'h1C |=> s_mode_tail)
      else $error("mode bytes out of order");
   a_rd_answer: assert property (reg_rd && ce_i |=> reg_rvalid)
      else $error("read not answered next cycle");
   a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("read answer without request");
   a_rd_pulse: assert property (reg_rd |=> !reg_rd)
      else $error("read strobe longer than one cycle");
   a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_wr_rd_excl: assert property (!(reg_wr && reg_rd))
      else $error("write and read strobes together");
   a_smp_hold: assert property (smp_valid && !smp_ready |=> smp_valid && $stable(smp_i) && $stable(smp_q))
      else $error("sample dropped or changed before taken");
endmodule : inco_sva

/* File: tb/inco_tb.sv */
`timescale 1ns/1ps
module inco_tb;
   logic        clk_i;
   logic        rst_i;
   logic        ce_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        ack;
   logic [15:0] out_i;
   logic [15:0] out_q;
   logic        out_valid;
   logic [7:0]  b;
   logic [31:0] q;
   int          errors;
   int          checks_done;
   // mode word, expected cfg_a, cfg_b, cfg_c; last row leaves the oscillator off
   logic [55:0] rows [7] = '{56'h00000DD6_062D1B, 56'h00000815_450900, 56'h00000403_630000,
                             56'h00001910_100912, 56'h00000000_700000, 56'h00000F78_083F36,
                             56'h00000E40_002424};

   always #50 clk_i = ~clk_i;

   inco_if #(.W(16)) u_inco_if ();
   inco_host #(.W(16)) u_inco_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .link(u_inco_if.host));
   inco_device #(.W(16)) u_inco_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .link(u_inco_if.dev), .out_i_o(out_i), .out_q_o(out_q), .out_valid_o(out_valid));
   inco_sva #(.W(16)) u_inco_sva (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
      .reg_wr(u_inco_if.reg_wr), .reg_rd(u_inco_if.reg_rd), .reg_addr(u_inco_if.reg_addr),
      .reg_wdata(u_inco_if.reg_wdata), .reg_rdata(u_inco_if.reg_rdata),
      .reg_rvalid(u_inco_if.reg_rvalid), .smp_valid(u_inco_if.smp_valid),
      .smp_ready(u_inco_if.smp_ready), .smp_i(u_inco_if.smp_i), .smp_q(u_inco_if.smp_q));

   task end_sim;
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 2000);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         errors++;
         end_sim();
      end
   endtask : wb

   // device bytes are reached through the command word, then status is polled
   task automatic dev_rd(input logic [7:0] a, output logic [7:0] r);
      logic [31:0] s;
      int          n;
      wb(8'h00, 1'b1, {15'h0000, 1'b1, a, 8'h00}, s);
      n = 0;
      do begin
         wb(8'h04, 1'b0, 32'h00000000, s);
         n++;
      end while (s[0] !== 1'b0 && n < 50);
      r = s[15:8];
      if (s[0] !== 1'b0) begin
         errors++;
         end_sim();
      end
   endtask : dev_rd

   task automatic dev_wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] s;
      wb(8'h00, 1'b1, {16'h0000, a, d}, s);
   endtask : dev_wr

   // feeds a steady sample while the output is watched; kind 0 holds, 1 flips, 2 turns a quarter per cycle
   task automatic seg(input logic [1:0] kind);
      logic signed [15:0] o0;
      logic signed [15:0] o1;
      logic signed [15:0] q0;
      logic signed [15:0] i1;
      logic signed [15:0] q1;
      logic [31:0]        s;
      fork
         repeat (12) wb(8'h08, 1'b1, 32'h00001000, s);
         begin
            repeat (40) @(posedge clk_i);
            o0 = out_i;
            q0 = out_q;
            @(posedge clk_i);
            i1 = out_i;
            q1 = out_q;
            repeat (3) @(posedge clk_i);
            o1 = out_i;
         end
      join
      if (kind == 2'h2) begin
         chk("turn_power", 32'(int'(o0) * int'(o0) + int'(q0) * int'(q0)), 32'h01000000);
         chk("turn_i", i1, -q0);
         chk("turn_q", q1, o0);
      end else begin
         chk("carrier_nz", 32'(o0 != 16'sh0000), 32'h00000001);
         chk("carrier_q", q0, 32'h00000000);
         if (kind == 2'h1) chk("carrier_flip", 32'((int'(o0) + int'(o1)) inside {[-1:1]}), 32'h00000001);
         else chk("carrier_hold", o1, o0);
      end
   endtask : seg

   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      ce_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hF;
      wdat = 32'h00000000;
      errors = 0;
      checks_done = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 7; k++) begin
         wb(8'h10, 1'b1, rows[k][55:24], q);
         dev_rd(8'h1C, b);
         chk("cfg_a", b, rows[k][23:16]);
         dev_rd(8'h1D, b);
         chk("cfg_b", b, rows[k][15:8]);
         dev_rd(8'h1E, b);
         chk("cfg_c", b, rows[k][7:0]);
      end
      wb(8'h0C, 1'b1, 32'h44332211, q);
      for (int k = 0; k < 4; k++) begin
         dev_rd(8'h30 + 8'(k), b);
         chk("word_byte", b, 8'h11 * 8'(k + 1));
      end
      dev_rd(8'h36, b);
      chk("update_bit", b, 8'h01);
      dev_rd(8'h40, b);
      chk("unmapped_dev", b, 8'h00);
      wb(8'h20, 1'b0, 32'h00000000, q);
      chk("unmapped_wb", q, 32'h00000000);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      dev_rd(8'h1C, b);
      chk("rst_cfg_a", b, 8'h70);
      dev_rd(8'h30, b);
      chk("rst_word", b, 8'h00);
      dev_rd(8'h36, b);
      chk("rst_update", b, 8'h00);
      chk("out_valid", out_valid, 1'b1);
      // zero word first so the accumulator starts at phase zero
      wb(8'h0C, 1'b1, 32'h00000000, q);
      wb(8'h10, 1'b1, 32'h00000C08, q);
      seg(2'h0);
      dev_wr(8'h33, 8'h80);
      seg(2'h0);
      dev_wr(8'h36, 8'h00);
      dev_wr(8'h36, 8'h01);
      seg(2'h1);
      // third stage mode 2 with the oscillator off
      wb(8'h10, 1'b1, 32'h00000D00, q);
      seg(2'h2);
      // output still rotates here, so an unchanged value proves the enable
      ce_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      q = {out_i, out_q};
      repeat (3) @(posedge clk_i);
      chk("ce_freeze", {out_i, out_q}, q);
      ce_i <= 1'b1;
      // 4x with premodulation: input sign alternates per input sample
      wb(8'h10, 1'b1, 32'h00000804, q);
      seg(2'h1);
      end_sim();
   end
endmodule : inco_tb
